// ---- core/subq_pkg.sv ----
// Shared constants and helpers for the subcode readout command link
package subq_pkg;
    // Command codes
    localparam logic [7:0] CMD_CLV = 8'hF1;
    localparam logic [7:0] CMD_QADDR = 8'hF2;
    localparam logic [7:0] CMD_QNEXT = 8'hF5;
    localparam logic [7:0] CMD_NOP = 8'hF8;
    // Servo parameter fields
    localparam int CLV_MODE_LSB = 0;
    localparam int CLV_MODE_W = 3;
    localparam int PKHOLD_BIT = 3;
    localparam int GAIN_BIT = 4;
    localparam int BOTTOM_BIT = 6;
    localparam int PHASE_BIT = 7;
    localparam logic [7:0] CLV_RESET = 8'h00;
    // Address parameter fields
    localparam int CLEAR_BIT = 7;
    localparam int QADDR_W = 4;
    // Readout pointer map
    localparam logic [3:0] PTR_Q_LAST = 4'h9;
    localparam logic [3:0] PTR_COUNTER = 4'hA;
    localparam logic [3:0] PTR_LPK_HI = 4'hB;
    localparam logic [3:0] PTR_LPK_LO = 4'hC;
    localparam logic [3:0] PTR_RPK_HI = 4'hD;
    localparam logic [3:0] PTR_RPK_LO = 4'hE;
    localparam logic [3:0] PTR_RESET = PTR_COUNTER;
    localparam int Q_BYTES = 10;
    localparam logic [3:0] CNT_MAX = 4'hF;
    // Controller registers and status bits
    localparam logic [1:0] HREG_CMD = 2'h0;
    localparam logic [1:0] HREG_STATUS = 2'h1;
    localparam logic [1:0] HREG_RESP = 2'h2;
    localparam int STS_BUSY = 0;
    localparam int STS_RESP_NEW = 1;
    localparam int STS_VALID = 2;
    localparam int STS_REFUSED = 3;

    // Commands that carry one parameter byte
    function automatic logic needs_param(input logic [7:0] cmd);
        needs_param = (cmd != CMD_QNEXT) && (cmd != CMD_NOP);
    endfunction : needs_param

    // Commands that are answered with one byte
    function automatic logic wants_reply(input logic [7:0] cmd);
        wants_reply = (cmd == CMD_QADDR) || (cmd == CMD_QNEXT);
    endfunction : wants_reply
endpackage : subq_pkg

// ---- core/subq_link_if.sv ----
// Byte link between the command controller and the readout logic
`timescale 1ns/1ps
interface subq_link_if (
    input logic MCLK,
    input logic RST
);
    logic cmd_stb;
    logic [7:0] cmd_data;
    logic reply_stb;
    logic [7:0] reply_data;
    logic readout_valid_flag;

    modport dev (
        input MCLK,
        input RST,
        input cmd_stb,
        input cmd_data,
        output reply_stb,
        output reply_data,
        output readout_valid_flag
    );

    modport host (
        input MCLK,
        input RST,
        output cmd_stb,
        output cmd_data,
        input reply_stb,
        input reply_data,
        input readout_valid_flag
    );
endinterface : subq_link_if

// ---- core/subq_peak_hold.sv ----
// One channel peak magnitude tracker with frame latch
`timescale 1ns/1ps
module subq_peak_hold (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_stb,
    input wire logic [15:0] sample,
    input wire logic frame_end,
    input wire logic clear,
    output logic [15:0] peak
);
    logic [15:0] running;
    logic [15:0] mag;

    // Magnitude of a signed sample; full-scale negative stays 8000
    assign mag = sample[15] ? 16'(~sample + 16'h0001) : sample;

    // Running maximum over the current subcode frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running <= 16'h0000;
        end else if (frame_end || clear) begin
            running <= 16'h0000;
        end else if (sample_stb && mag > running) begin
            running <= mag; // R15
        end
    end

    // Whole 16-bit word latched at once so both bytes match
    // Frame latch beats a clear in the same cycle, matching the valid flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peak <= 16'h0000;
        end else if (frame_end) begin
            peak <= running; // R22
        end else if (clear) begin
            peak <= 16'h0000;
        end
    end
endmodule : subq_peak_hold

// ---- core/subq_readout.sv ----
// Device end: command decode, servo parameters, subcode and peak readout
// What this block and the host controller do
// (R1) Servo parameter low bits set CLV mode
// (R2) One bit picks peak hold READ_FRAME_CLOCK/2 or /4
// (R3) One bit picks lead-in gain -12 or 0 dB
// (R4) One bit picks bottom hold /16 or /32
// (R5) One bit picks phase compare /4 or /8
// (R6) Address command: clear bit, 4-bit pointer
// (R7) Host gives only pointers 0 to E
// (R8) Pointers 0-9 subcode, A counter, B-E peaks
// (R9) Pointer advances after every read byte
// (R10) Only CRC-good frames are stored
// (R11) Counter byte: errors high, updates low
// (R12) Update count wraps, held on CRC error
// (R13) Error count saturates, clears on good frame
// (R14) Pointers B-E give peak bytes high/low
// (R15) Peak is frame maximum sample magnitude
// (R16) Host checks valid flag for peak bytes
// (R17) Next command replies current byte, advances
// (R18) Other commands reset pointer to A
// (R19) After A pointer wraps to zero
// (R20) Host uses address then next commands
// (R21) No-op command changes nothing
// (R22) Peak bytes of a channel latched together
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module subq_readout (
    subq_link_if.dev LINK,
    input wire logic Q_FRAME_STB,
    input wire logic Q_CRC_OK,
    input wire logic [79:0] Q_FRAME,
    input wire logic SAMPLE_STB,
    input wire logic [15:0] LEFT_SAMPLE,
    input wire logic [15:0] RIGHT_SAMPLE,
    input wire logic SUBFRAME_END,
    output logic [2:0] CLV_MODE,
    output logic PEAK_HOLD_DIV4,
    output logic LEADIN_GAIN_0DB,
    output logic BOTTOM_HOLD_DIV32,
    output logic PHASE_DIV8
);
    import subq_pkg::*;

    typedef enum logic [1:0] {
        ST_CMD = 2'b01,
        ST_PARAM = 2'b10
    } dev_state_t;

    dev_state_t state;
    logic [7:0] cmd;
    logic [7:0] clv_param;
    logic [3:0] ptr;
    logic [7:0] qbytes [Q_BYTES];
    logic [3:0] err_count;
    logic [3:0] upd_count;
    logic [15:0] peaks [2];
    logic [15:0] samples [2];
    logic cmd_taken;
    logic param_taken;
    logic addr_param;
    logic peak_clear;
    logic reply_stb;
    logic [7:0] reply_data;
    logic valid_flag;

    // Pointer step: wraps after the counter entry and after the last peak byte
    function automatic logic [3:0] step_ptr(input logic [3:0] p);
        if (p == PTR_COUNTER || p >= PTR_RPK_LO) begin
            step_ptr = 4'h0; // R19
        end else begin
            step_ptr = 4'(p + 4'h1);
        end
    endfunction : step_ptr

    // Byte at a pointer position
    function automatic logic [7:0] read_byte(input logic [3:0] p);
        case (p)
            PTR_COUNTER: read_byte = {err_count, upd_count}; // R11
            PTR_LPK_HI: read_byte = peaks[0][15:8]; // R14
            PTR_LPK_LO: read_byte = peaks[0][7:0];
            PTR_RPK_HI: read_byte = peaks[1][15:8];
            PTR_RPK_LO: read_byte = peaks[1][7:0];
            default: read_byte = (p <= PTR_Q_LAST) ? qbytes[p] : 8'h00; // R8
        endcase
    endfunction : read_byte

    assign cmd_taken = (state == ST_CMD) && LINK.cmd_stb;
    assign param_taken = (state == ST_PARAM) && LINK.cmd_stb;
    assign addr_param = param_taken && (cmd == CMD_QADDR);
    assign peak_clear = addr_param && LINK.cmd_data[CLEAR_BIT]; // R6

    // Command byte then optional parameter byte
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            state <= ST_CMD;
            cmd <= CMD_NOP;
        end else begin
            case (state)
                ST_CMD: begin
                    if (LINK.cmd_stb) begin
                        cmd <= LINK.cmd_data;
                        if (needs_param(LINK.cmd_data)) begin
                            state <= ST_PARAM;
                        end
                    end
                end
                ST_PARAM: begin
                    if (LINK.cmd_stb) begin
                        state <= ST_CMD;
                    end
                end
                default: state <= ST_CMD;
            endcase
        end
    end

    // Servo parameter byte
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            clv_param <= CLV_RESET;
        end else if (param_taken && cmd == CMD_CLV) begin
            clv_param <= LINK.cmd_data; // R1
        end
    end

    assign CLV_MODE = clv_param[CLV_MODE_LSB +: CLV_MODE_W]; // R1
    assign PEAK_HOLD_DIV4 = clv_param[PKHOLD_BIT]; // R2
    assign LEADIN_GAIN_0DB = clv_param[GAIN_BIT]; // R3
    assign BOTTOM_HOLD_DIV32 = clv_param[BOTTOM_BIT]; // R4
    assign PHASE_DIV8 = clv_param[PHASE_BIT]; // R5

    // Readout pointer; the no-op and the address command byte leave it alone
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            ptr <= PTR_RESET;
        end else if (addr_param) begin
            ptr <= step_ptr(LINK.cmd_data[QADDR_W-1:0]); // R9
        end else if (cmd_taken && LINK.cmd_data == CMD_QNEXT) begin
            ptr <= step_ptr(ptr); // R17
        end else if (cmd_taken && LINK.cmd_data != CMD_QADDR && LINK.cmd_data != CMD_NOP) begin
            ptr <= PTR_RESET; // R18 R21
        end
    end

    // One reply byte per address or next command
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            reply_stb <= 1'b0;
            reply_data <= 8'h00;
        end else if (addr_param) begin
            reply_stb <= 1'b1;
            reply_data <= read_byte(LINK.cmd_data[QADDR_W-1:0]); // R6
        end else if (cmd_taken && LINK.cmd_data == CMD_QNEXT) begin
            reply_stb <= 1'b1;
            reply_data <= read_byte(ptr); // R17
        end else begin
            reply_stb <= 1'b0;
            reply_data <= 8'h00;
        end
    end

    assign LINK.reply_stb = reply_stb;
    assign LINK.reply_data = reply_data;

    // Subcode store; a failed frame never reaches the readout bytes
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            for (int i = 0; i < Q_BYTES; i++) begin
                qbytes[i] <= 8'h00;
            end
        end else if (Q_FRAME_STB && Q_CRC_OK) begin
            for (int i = 0; i < Q_BYTES; i++) begin
                qbytes[i] <= Q_FRAME[79 - 8 * i -: 8]; // R10
            end
        end
    end

    // Frame and error counters
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            upd_count <= 4'h0;
            err_count <= 4'h0;
        end else if (Q_FRAME_STB) begin
            if (Q_CRC_OK) begin
                upd_count <= 4'(upd_count + 4'h1); // R12
                err_count <= 4'h0; // R13
            end else if (err_count != CNT_MAX) begin
                err_count <= 4'(err_count + 4'h1); // R13
            end
        end
    end

    assign samples[0] = LEFT_SAMPLE;
    assign samples[1] = RIGHT_SAMPLE;

    // Left and right peak trackers
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_peak
            subq_peak_hold u_peak (
                .clk(LINK.MCLK),
                .rst(LINK.RST),
                .sample_stb(SAMPLE_STB),
                .sample(samples[ch]),
                .frame_end(SUBFRAME_END),
                .clear(peak_clear),
                .peak(peaks[ch])
            );
        end
    endgenerate

    // Peak data valid: set at frame latch, dropped by a clear; set wins
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            valid_flag <= 1'b0;
        end else if (SUBFRAME_END) begin
            valid_flag <= 1'b1;
        end else if (peak_clear) begin
            valid_flag <= 1'b0;
        end
    end

    assign LINK.readout_valid_flag = valid_flag;
endmodule : subq_readout

// ---- core/subq_host_ctrl.sv ----
// Controller end: sends commands from software registers, collects replies
`timescale 1ns/1ps
module subq_host_ctrl (
    subq_link_if.host LINK,
    input wire logic [1:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA
);
    import subq_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_PARAM = 3'b010,
        H_WAIT = 3'b100
    } host_state_t;

    host_state_t state;
    logic [7:0] cmd;
    logic [7:0] param;
    logic cmd_stb;
    logic [7:0] cmd_data;
    logic [7:0] resp;
    logic resp_valid_flag;
    logic resp_new;
    logic refused;
    logic issue;
    logic bad_ptr;

    // Pointers above E are never sent
    assign bad_ptr = (WDATA[7:0] == CMD_QADDR) && (WDATA[8 +: QADDR_W] > PTR_RPK_LO); // R7
    assign issue = WR && (ADDR == HREG_CMD) && (state == H_IDLE) && !bad_ptr;

    // Command sequencer: one byte per cycle onto the link
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            state <= H_IDLE;
            cmd <= CMD_NOP;
            param <= 8'h00;
            cmd_stb <= 1'b0;
            cmd_data <= 8'h00;
        end else begin
            cmd_stb <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (issue) begin
                        cmd <= WDATA[7:0];
                        param <= WDATA[15:8];
                        cmd_stb <= 1'b1;
                        cmd_data <= WDATA[7:0];
                        if (needs_param(WDATA[7:0])) begin
                            state <= H_PARAM;
                        end else if (wants_reply(WDATA[7:0])) begin
                            state <= H_WAIT; // R20
                        end
                    end
                end
                H_PARAM: begin
                    cmd_stb <= 1'b1;
                    cmd_data <= param; // R6
                    state <= wants_reply(cmd) ? H_WAIT : H_IDLE;
                end
                H_WAIT: begin
                    if (LINK.reply_stb) begin
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    assign LINK.cmd_stb = cmd_stb;
    assign LINK.cmd_data = cmd_data;

    // Reply byte with the valid flag seen beside it, for the peak bytes
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            resp <= 8'h00;
            resp_valid_flag <= 1'b0;
        end else if (state == H_WAIT && LINK.reply_stb) begin
            resp <= LINK.reply_data;
            resp_valid_flag <= LINK.readout_valid_flag; // R16
        end
    end

    // New-reply flag: a reply in the same cycle as a read keeps it set
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            resp_new <= 1'b0;
        end else if (state == H_WAIT && LINK.reply_stb) begin
            resp_new <= 1'b1;
        end else if (RD && ADDR == HREG_RESP) begin
            resp_new <= 1'b0;
        end
    end

    // Refused writes: busy or forbidden pointer; cleared by the next issue
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            refused <= 1'b0;
        end else if (WR && ADDR == HREG_CMD) begin
            refused <= !issue;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge LINK.MCLK or posedge LINK.RST) begin
        if (LINK.RST) begin
            RDATA <= 16'h0000;
        end else if (RD && ADDR == HREG_STATUS) begin
            RDATA <= {12'h000, refused, LINK.readout_valid_flag, resp_new, state != H_IDLE};
        end else if (RD && ADDR == HREG_RESP) begin
            RDATA <= {7'h00, resp_valid_flag, resp};
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule : subq_host_ctrl

// ---- verification/subq_link_monitor.sv ----
// Protocol checker for the byte link between controller and readout logic
`timescale 1ns/1ps
module subq_link_monitor (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic cmd_stb,
    input wire logic [7:0] cmd_data,
    input wire logic reply_stb,
    input wire logic [7:0] reply_data,
    input wire logic readout_valid_flag
);
    import subq_pkg::*;
    logic in_param;
    logic [7:0] last_cmd;
    logic qaddr_param;
    logic qnext_cmd;

    // Command and parameter share one strobe, so track which byte is due
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            in_param <= 1'b0;
        end else if (cmd_stb) begin
            in_param <= !in_param && needs_param(cmd_data);
        end
    end

    // Last command byte, kept for judging its parameter
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            last_cmd <= 8'h00;
        end else if (cmd_stb && !in_param) begin
            last_cmd <= cmd_data;
        end
    end

    // Address parameter on the wire
    assign qaddr_param = cmd_stb && in_param && last_cmd == CMD_QADDR;
    // Next command byte on the wire, not a parameter that happens to match
    assign qnext_cmd = cmd_stb && !in_param && cmd_data == CMD_QNEXT;

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence qaddr_s;
        cmd_stb && !in_param && cmd_data == CMD_QADDR ##1 cmd_stb;
    endsequence
    sequence qnext_s;
        cmd_stb && !in_param && cmd_data == CMD_QNEXT;
    endsequence
    sequence pulse_s;
        reply_stb ##1 !reply_stb;
    endsequence

    AST_QADDR_REPLY: assert property (qaddr_s |=> pulse_s)
        else $error("no single reply after address parameter");
    AST_QNEXT_REPLY: assert property (qnext_s |=> pulse_s)
        else $error("no single reply after next command");
    AST_REPLY_CAUSE: assert property (reply_stb |-> $past(qaddr_param || qnext_cmd))
        else $error("reply without a read request");
    AST_REPLY_IDLE_ZERO: assert property (!reply_stb |-> reply_data == 8'h00)
        else $error("reply data not zero outside reply");
    AST_QADDR_RANGE: assert property (qaddr_param |-> cmd_data[3:0] <= 4'hE)
        else $error("prohibited pointer sent");
    AST_PARAM_FOLLOWS: assert property (cmd_stb && !in_param && needs_param(cmd_data) |=> cmd_stb && in_param)
        else $error("parameter byte not sent next");
    AST_QNEXT_SPACING: assert property (qnext_s |=> !cmd_stb [*2])
        else $error("byte sent before reply collected");
    AST_FLAG_CLEAR: assert property ($fell(readout_valid_flag) |-> $past(qaddr_param && cmd_data[CLEAR_BIT]))
        else $error("valid flag dropped without clear request");
    AST_NOP_SILENT: assert property (cmd_stb && !in_param && cmd_data == CMD_NOP |=> !reply_stb)
        else $error("reply after no-op");
endmodule : subq_link_monitor

// ---- verification/tb_subq_readout_cmds.sv ----
// Self-checking bench: controller and readout joined over the byte link
`timescale 1ns/1ps
module tb_subq_readout_cmds;
    import subq_pkg::*;
    localparam logic [79:0] FRAME_A = 80'h00112233445566778899;
    localparam logic [79:0] FRAME_B = 80'hFFEEDDCCBBAA99887766;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic q_frame_stb = 1'b0;
    logic q_crc_ok = 1'b0;
    logic [79:0] q_frame = 80'h0;
    logic sample_stb = 1'b0;
    logic [15:0] left = 16'h0000;
    logic [15:0] right = 16'h0000;
    logic subframe_end = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [2:0] clv_mode;
    logic pk_div4, gain_0db, bot_div32, ph_div8;
    logic [15:0] v;
    logic [7:0] sp [2] = '{8'hDD, 8'h22};
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Free-running system clock
    always #25 mclk = ~mclk;

    subq_link_if subq_link_if_i (.MCLK(mclk), .RST(rst));
    subq_readout subq_readout_i (.LINK(subq_link_if_i), .Q_FRAME_STB(q_frame_stb), .Q_CRC_OK(q_crc_ok),
        .Q_FRAME(q_frame), .SAMPLE_STB(sample_stb), .LEFT_SAMPLE(left), .RIGHT_SAMPLE(right),
        .SUBFRAME_END(subframe_end), .CLV_MODE(clv_mode), .PEAK_HOLD_DIV4(pk_div4),
        .LEADIN_GAIN_0DB(gain_0db), .BOTTOM_HOLD_DIV32(bot_div32), .PHASE_DIV8(ph_div8));
    subq_host_ctrl subq_host_ctrl_i (.LINK(subq_link_if_i), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata));
    subq_link_monitor monitor_i (.MCLK(mclk), .RST(rst), .cmd_stb(subq_link_if_i.cmd_stb),
        .cmd_data(subq_link_if_i.cmd_data), .reply_stb(subq_link_if_i.reply_stb),
        .reply_data(subq_link_if_i.reply_data), .readout_valid_flag(subq_link_if_i.readout_valid_flag));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t ns: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Bus cycles; each ends one edge after dropping its strobe
    task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : reg_wr

    task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask : reg_rd

    // Issue a command, then poll busy with a bounded count
    task automatic cmd(input logic [7:0] c, input logic [7:0] p);
        reg_wr(HREG_CMD, {p, c});
        for (int i = 0; i < 20; i++) begin
            reg_rd(HREG_STATUS, v);
            if (v[STS_BUSY] === 1'b0) break;
        end
        chk({15'h0, v[STS_BUSY]}, 16'h0000, "busy stuck");
    endtask : cmd

    task automatic ask(input logic [7:0] c, input logic [7:0] p, input logic [7:0] e);
        cmd(c, p);
        chk({15'h0, v[STS_RESP_NEW]}, 16'h0001, "reply new");
        reg_rd(HREG_RESP, v);
        chk({8'h00, v[7:0]}, {8'h00, e}, "reply byte");
    endtask : ask

    task automatic frame(input logic ok, input logic [79:0] d);
        q_frame_stb <= 1'b1;
        q_crc_ok <= ok;
        q_frame <= d;
        @(posedge mclk);
        q_frame_stb <= 1'b0;
        @(posedge mclk);
    endtask : frame

    task automatic sample(input logic [15:0] l, input logic [15:0] r);
        sample_stb <= 1'b1;
        left <= l;
        right <= r;
        @(posedge mclk);
        sample_stb <= 1'b0;
        @(posedge mclk);
    endtask : sample

    task automatic subframe();
        subframe_end <= 1'b1;
        @(posedge mclk);
        subframe_end <= 1'b0;
        @(posedge mclk);
    endtask : subframe

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // Hang guard: whole run needs a few hundred cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({13'h0, clv_mode}, 16'h0000, "servo reset");
        chk(rdata, 16'h0000, "rdata reset");
        ask(CMD_QNEXT, 8'h00, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            cmd(CMD_CLV, sp[i]);
            chk({13'h0, clv_mode}, {13'h0, sp[i][2:0]}, "clv mode");
            chk({15'h0, pk_div4}, {15'h0, sp[i][PKHOLD_BIT]}, "peak hold");
            chk({15'h0, gain_0db}, {15'h0, sp[i][GAIN_BIT]}, "gain");
            chk({15'h0, bot_div32}, {15'h0, sp[i][BOTTOM_BIT]}, "bottom hold");
            chk({15'h0, ph_div8}, {15'h0, sp[i][PHASE_BIT]}, "phase");
        end
        $display("test servo done");
        // One good frame, then bad frames that must not be stored
        frame(1'b1, FRAME_A);
        repeat (2) frame(1'b0, FRAME_B);
        ask(CMD_QADDR, 8'h09, 8'h99);
        ask(CMD_QNEXT, 8'h00, 8'h21);
        ask(CMD_QNEXT, 8'h00, 8'h00);
        ask(CMD_QNEXT, 8'h00, 8'h11);
        ask(CMD_QADDR, 8'h03, 8'h33);
        cmd(CMD_NOP, 8'h00);
        ask(CMD_QNEXT, 8'h00, 8'h44);
        cmd(CMD_CLV, 8'h00);
        ask(CMD_QNEXT, 8'h00, 8'h21);
        repeat (15) frame(1'b0, FRAME_B);
        ask(CMD_QADDR, 8'h0A, 8'hF1);
        frame(1'b1, FRAME_B);
        ask(CMD_QADDR, 8'h0A, 8'h02);
        ask(CMD_QNEXT, 8'h00, 8'hFF);
        $display("test subcode done");
        // Peak window: negative and full-scale magnitudes
        subframe();
        sample(16'h1234, 16'h0100);
        sample(16'hE000, 16'h7FFF);
        sample(16'h0F00, 16'h8001);
        subframe();
        reg_rd(HREG_STATUS, v);
        chk({15'h0, v[STS_VALID]}, 16'h0001, "flag set");
        ask(CMD_QADDR, 8'h0B, 8'h20);
        chk({15'h0, v[8]}, 16'h0001, "flag with reply");
        ask(CMD_QNEXT, 8'h00, 8'h00);
        ask(CMD_QNEXT, 8'h00, 8'h7F);
        ask(CMD_QNEXT, 8'h00, 8'hFF);
        ask(CMD_QADDR, 8'h8D, 8'h7F);
        reg_rd(HREG_STATUS, v);
        chk({15'h0, v[STS_VALID]}, 16'h0000, "flag cleared");
        ask(CMD_QNEXT, 8'h00, 8'h00);
        $display("test peaks done");
        // Prohibited pointer is refused; unmapped read gives zero
        cmd(CMD_QADDR, 8'h0F);
        reg_rd(HREG_STATUS, v);
        chk({15'h0, v[STS_REFUSED]}, 16'h0001, "refused");
        chk({15'h0, v[STS_RESP_NEW]}, 16'h0000, "reply new cleared");
        reg_rd(2'h3, v);
        chk(v, 16'h0000, "unmapped read");
        $display("test refusal done");
        end_of_test();
    end
endmodule : tb_subq_readout_cmds
